// [src/wdt_regs.vh]
/*
  Register map, field positions and timing constants of the windowed watchdog.
  Assumes inclusion by the watchdog design files and the bench.
*/
`ifndef WDT_REGS_VH
`define WDT_REGS_VH
// Byte addresses: printed offsets 0x00 and 0x01 are indexes, address is index times four
`define CTRL_INDEX 8'h00
`define STATE_INDEX 8'h01
`define ADDR_CTRL 12'h000
`define ADDR_STATE 12'h004
`define ADDR_GUARD 12'h008
`define ADDR_CMD 12'h00c
// Control fields
`define WIN_HI 7
`define WIN_LO 4
`define PER_HI 3
`define PER_LO 0
`define CODE_OFF 4'h0
`define CODE_MAX 4'hb
// State fields
`define LOCK_BIT 7
`define BUSY_BIT 0
// Guard and command registers
`define KEY_VALUE 8'hd8
`define KEY_WINDOW 3'h4
`define CMD_RESTART_BIT 0
// Watchdog tick: 1 kHz from 20 MHz
`define TICK_HZ 32'd1000
`define MCLK_HZ 32'd20000000
`define BASE_SHIFT 3
`define SYNC_STAGES 2'h2
`endif

// [src/sync_pulse.v]
/*
  Two-stage level synchroniser with a delay register and an unregistered edge pulse decoded after it.
  Assumes the input is a level from another clock domain or a pin.
*/
`timescale 1ns/1ps
`include "wdt_regs.vh"
module sync_pulse (
  input wire mclk,
  input wire reset_n,
  input wire level_in,
  output wire level_out,
  output wire rise_out
);
  reg meta_reg;
  reg sync_reg;
  reg last_reg;

  // Only sync_reg reads meta_reg
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= level_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign level_out = sync_reg;
  assign rise_out = sync_reg & ~last_reg;
endmodule

// [src/tick_divider.v]
/*
  Divider that turns mclk into a one-cycle tick at the watchdog rate.
  Assumes mclk runs at the rate given in the register header.
*/
`timescale 1ns/1ps
`include "wdt_regs.vh"
module tick_divider #(
  parameter [31:0] DIVIDE = `MCLK_HZ / `TICK_HZ
) (
  input wire mclk,
  input wire reset_n,
  output reg tick
);
  reg [31:0] count_reg;

  // Free-running count, so the tick keeps going through debug halt
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= 32'h0;
      tick <= 1'b0;
    end else if (count_reg >= DIVIDE - 32'd1) begin
      count_reg <= 32'h0;
      tick <= 1'b1;
    end else begin
      count_reg <= count_reg + 32'd1;
      tick <= 1'b0;
    end
  end
endmodule

// [src/windowed_watchdog_timer.v]
/*
  Windowed watchdog with Normal and Window modes, key-guarded control,
  lock bit, restart synchronisation and AXI4-Lite register slave.
  Assumes one clock mclk; the watchdog rate is an enable from a divider,
  and the reset controller captures the one-cycle reset request.
*/
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "wdt_regs.vh"
module windowed_watchdog_timer #(
  parameter [31:0] TICK_DIVIDE = `MCLK_HZ / `TICK_HZ
) (
  input wire mclk,
  input wire reset_n,
  input wire [7:0] boot_config_fuse,
  input wire boot_load,
  input wire debug_halt,
  input wire debug_mode,
  input wire watchdog_restart_instr,
  input wire instr_retire,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg system_reset_req
);
  localparam ST_IDLE = 2'b00;
  localparam ST_WAIT = 2'b01;
  localparam ST_CLOSED = 2'b10;
  localparam ST_OPEN = 2'b11;

  // Code 1..11 gives 8 << (code-1) ticks; reserved codes give zero
  function [13:0] code_ticks;
    input [3:0] code;
    begin
      if (code == `CODE_OFF || code > `CODE_MAX)
        code_ticks = 14'h0;
      else
        code_ticks = 14'h1 << (code + `BASE_SHIFT - 4'h1);
    end
  endfunction

  function is_valid;
    input [3:0] code;
    begin
      is_valid = (code != `CODE_OFF) && (code <= `CODE_MAX);
    end
  endfunction

  wire tick;
  wire dbg_level;
  wire halt_level;
  wire restart_rise;
  reg [7:0] control_reg;
  reg [7:0] ctrl_wd_reg;
  reg lock_reg;
  reg busy_reg;
  reg [1:0] busy_cnt_reg;
  reg [2:0] key_cnt_reg;
  reg restart_pend_reg;
  reg [1:0] restart_cnt_reg;
  reg [1:0] state_reg;
  reg [13:0] count_reg;
  reg aw_held_reg;
  reg w_held_reg;
  reg [11:0] awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;

  tick_divider #(.DIVIDE(TICK_DIVIDE)) u_tick (
    .mclk(mclk),
    .reset_n(reset_n),
    .tick(tick)
  );

  // Restart, debug and halt come from the CPU pipeline; treated as foreign
  sync_pulse u_restart (
    .mclk(mclk),
    .reset_n(reset_n),
    .level_in(watchdog_restart_instr),
    .level_out(),
    .rise_out(restart_rise)
  );

  sync_pulse u_debug (
    .mclk(mclk),
    .reset_n(reset_n),
    .level_in(debug_mode),
    .level_out(dbg_level),
    .rise_out()
  );

  sync_pulse u_halt (
    .mclk(mclk),
    .reset_n(reset_n),
    .level_in(debug_halt),
    .level_out(halt_level),
    .rise_out()
  );

  // AXI write channels: each held until both are present
  wire wr_fire = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held_reg & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  wire key_open = (key_cnt_reg != 3'h0);
  wire lane0 = wstrb_reg[0];
  wire wr_ctrl = wr_fire && awaddr_reg == `ADDR_CTRL && lane0;
  wire wr_state = wr_fire && awaddr_reg == `ADDR_STATE && lane0;
  wire wr_guard = wr_fire && awaddr_reg == `ADDR_GUARD && lane0;
  wire wr_cmd = wr_fire && awaddr_reg == `ADDR_CMD && lane0;
  wire wr_known = (awaddr_reg == `ADDR_CTRL) || (awaddr_reg == `ADDR_STATE) ||
    (awaddr_reg == `ADDR_GUARD) || (awaddr_reg == `ADDR_CMD);
  wire ctrl_ok = wr_ctrl && key_open && !lock_reg && !busy_reg;
  wire sw_restart = wr_cmd && wdata_reg[`CMD_RESTART_BIT];

  // Bus write path
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 12'h0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= {s_axi_awaddr[11:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Bus read path; unmapped reads answer SLVERR with zero data
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      case ({s_axi_araddr[11:2], 2'b00})
        `ADDR_CTRL: s_axi_rdata <= {24'h0, control_reg};
        `ADDR_STATE: s_axi_rdata <= {24'h0, lock_reg, 6'h0, busy_reg};
        `ADDR_GUARD: s_axi_rdata <= {29'h0, key_cnt_reg};
        `ADDR_CMD: s_axi_rdata <= 32'h0;
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Key window counts retired instructions after the key write
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      key_cnt_reg <= 3'h0;
    end else if (wr_guard && wdata_reg[7:0] == `KEY_VALUE) begin
      key_cnt_reg <= `KEY_WINDOW;
    end else if (ctrl_ok || (wr_state && key_open)) begin
      key_cnt_reg <= 3'h0;
    end else if (instr_retire && key_open) begin
      key_cnt_reg <= key_cnt_reg - 3'h1;
    end
  end

  // Control and lock; fuse load at boot, key-guarded writes after
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      control_reg <= 8'h0;
      lock_reg <= 1'b0;
    end else if (boot_load) begin
      control_reg <= boot_config_fuse;
      lock_reg <= (boot_config_fuse[`PER_HI:`PER_LO] != `CODE_OFF);
    end else begin
      if (ctrl_ok)
        control_reg <= wdata_reg[7:0];
      if (wr_state && key_open) begin
        if (wdata_reg[`LOCK_BIT])
          lock_reg <= 1'b1;
        else if (dbg_level)
          lock_reg <= 1'b0;
      end
    end
  end

  // Busy spans two ticks so the new value is seen in the tick domain
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      busy_reg <= 1'b0;
      busy_cnt_reg <= 2'h0;
      ctrl_wd_reg <= 8'h0;
    end else if (ctrl_ok || boot_load) begin
      busy_reg <= 1'b1;
      busy_cnt_reg <= `SYNC_STAGES;
    end else if (busy_reg && tick) begin
      if (busy_cnt_reg == 2'h1) begin
        busy_reg <= 1'b0;
        ctrl_wd_reg <= control_reg;
      end
      busy_cnt_reg <= busy_cnt_reg - 2'h1;
    end
  end

  wire [3:0] win_code = ctrl_wd_reg[`WIN_HI:`WIN_LO];
  wire [3:0] per_code = ctrl_wd_reg[`PER_HI:`PER_LO];
  wire enabled = is_valid(per_code);
  wire window_mode = is_valid(win_code);
  wire [13:0] open_len = code_ticks(per_code);
  wire [13:0] closed_len = code_ticks(win_code);
  wire restart_take = (restart_rise || sw_restart) && !restart_pend_reg;
  wire restart_done = restart_pend_reg && tick && restart_cnt_reg == 2'h1;

  // Restart takes two ticks after arrival; requests meanwhile are dropped
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      restart_pend_reg <= 1'b0;
      restart_cnt_reg <= 2'h0;
    end else if (restart_take) begin
      restart_pend_reg <= 1'b1;
      restart_cnt_reg <= `SYNC_STAGES;
    end else if (restart_pend_reg && tick) begin
      restart_cnt_reg <= restart_cnt_reg - 2'h1;
      if (restart_cnt_reg == 2'h1)
        restart_pend_reg <= 1'b0;
    end
  end

  // Timer state machine; the count advances once per watchdog tick, while the IDLE exit, halt and disable act on any mclk
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      count_reg <= 14'h0;
      system_reset_req <= 1'b0;
    end else begin
      system_reset_req <= 1'b0;
      if (halt_level) begin
        count_reg <= 14'h0;
        state_reg <= ST_IDLE;
      end else if (!enabled) begin
        state_reg <= ST_IDLE;
        count_reg <= 14'h0;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            count_reg <= 14'h0;
            // Fresh window mode, or return from halt in window mode, waits
            if (window_mode)
              state_reg <= ST_WAIT;
            else
              state_reg <= ST_OPEN;
          end
          ST_WAIT: begin
            // Normal-length timeout runs while waiting for first restart
            if (restart_done) begin
              count_reg <= 14'h0;
              state_reg <= ST_CLOSED;
            end else if (tick) begin
              if (count_reg + 14'h1 >= open_len) begin
                system_reset_req <= 1'b1;
                count_reg <= 14'h0;
              end else begin
                count_reg <= count_reg + 14'h1;
              end
            end
            if (!window_mode)
              state_reg <= ST_OPEN;
          end
          ST_CLOSED: begin
            if (restart_done) begin
              system_reset_req <= 1'b1;
              count_reg <= 14'h0;
            end else if (tick) begin
              if (count_reg + 14'h1 >= closed_len) begin
                count_reg <= 14'h0;
                state_reg <= ST_OPEN;
              end else begin
                count_reg <= count_reg + 14'h1;
              end
            end
            if (!window_mode)
              state_reg <= ST_OPEN;
          end
          ST_OPEN: begin
            if (restart_done) begin
              count_reg <= 14'h0;
              if (window_mode)
                state_reg <= ST_CLOSED;
            end else if (tick) begin
              if (count_reg + 14'h1 >= open_len) begin
                system_reset_req <= 1'b1;
                count_reg <= 14'h0;
                if (window_mode)
                  state_reg <= ST_CLOSED;
              end else begin
                count_reg <= count_reg + 14'h1;
              end
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end
endmodule

// [verif/wdt_properties.sv]
/*
  Bus and reset-request properties of the watchdog top.
  Assumes a bind to the top module's ports; one clock, async low reset.
*/
`timescale 1ns/1ps
module wdt_properties (
  input wire mclk,
  input wire reset_n,
  input wire debug_halt,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire system_reset_req
);
  // One domain, so clock and reset are shared by every property
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  pulse_width_a: assert property (system_reset_req |=> !system_reset_req)
    else $error("reset request wider than one cycle");
  halt_quiet_a: assert property (debug_halt [*6] |-> !system_reset_req)
    else $error("reset request during debug halt");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:3] s_axi_bvalid)
    else $error("write response missing");
  write_retire_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken during response");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  read_retire_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken during data");
  unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr[11:2] > 10'h003 |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule
bind windowed_watchdog_timer wdt_properties props (.mclk(mclk), .reset_n(reset_n),
  .debug_halt(debug_halt), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .system_reset_req(system_reset_req));

// [verif/cpu_model.sv]
/*
  CPU-side model: restart instruction level and retirement pulses.
  Assumes the bench pulses restart_go and holds retire_run.
*/
`timescale 1ns/1ps
module cpu_model (
  input wire mclk,
  input wire reset_n,
  input wire restart_go,
  input wire retire_run,
  output wire watchdog_restart_instr,
  output reg instr_retire
);
  reg [2:0] hold_reg;
  // Level held four cycles so the two-stage sync cannot miss it
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hold_reg <= 3'h0;
      instr_retire <= 1'b0;
    end else begin
      if (restart_go)
        hold_reg <= 3'h4;
      else if (hold_reg != 3'h0)
        hold_reg <= hold_reg - 3'h1;
      instr_retire <= retire_run & ~instr_retire;
    end
  end
  assign watchdog_restart_instr = (hold_reg != 3'h0);
endmodule

// [verif/tb.sv]
/*
  Self-checking bench of the windowed watchdog over AXI4-Lite.
  Assumes the watchdog tick divider is set to 4 mclk cycles.
*/
`timescale 1ns/1ps
`include "wdt_regs.vh"
module tb;
  reg mclk = 0, reset_n = 0, boot_load = 0, debug_halt = 0, debug_mode = 0, go = 0, run = 0;
  reg [7:0] fuse = 8'h00, seed = 8'h31;
  reg [11:0] awaddr = 0, araddr = 0;
  reg [31:0] wdata = 0;
  reg awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  wire awready, wready, bvalid, arready, rvalid, rst_req, restart, retire;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  reg [33:0] expq[$];
  reg [1:0] bq[$];
  integer errors = 0, samples_checked = 0, cycles = 0, pulses = 0, p0, n;
  always #25 mclk = ~mclk;
  windowed_watchdog_timer #(.TICK_DIVIDE(32'd4)) uut (.mclk(mclk), .reset_n(reset_n),
    .boot_config_fuse(fuse), .boot_load(boot_load), .debug_halt(debug_halt),
    .debug_mode(debug_mode), .watchdog_restart_instr(restart), .instr_retire(retire),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .system_reset_req(rst_req));
  cpu_model cpu (.mclk(mclk), .reset_n(reset_n), .restart_go(go), .retire_run(run),
    .watchdog_restart_instr(restart), .instr_retire(retire));
  function [7:0] lfsr(input [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task check(input [33:0] seen, input [33:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("MISMATCH %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task end_of_test;
    begin
      if (errors == 0 && samples_checked > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  // Master releases each channel only at the edge it was taken
  task wr(input [11:0] a, input [7:0] d);
    reg ta, tw;
    begin
      @(posedge mclk);
      bq.push_back((a[11:2] > 10'h003) ? 2'b10 : 2'b00);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      ta = 0;
      tw = 0;
      while (!(ta && tw)) begin
        @(negedge mclk);
        ta = ta | (awvalid & awready);
        tw = tw | (wvalid & wready);
        @(posedge mclk);
        if (ta) awvalid <= 1'b0;
        if (tw) wvalid <= 1'b0;
      end
      do @(negedge mclk); while (!bvalid);
      @(posedge mclk);
      bready <= 1'b0;
    end
  endtask
  task rd(input [11:0] a, input [33:0] e);
    begin
      @(posedge mclk);
      expq.push_back(e);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(negedge mclk); while (!arready);
      @(posedge mclk);
      arvalid <= 1'b0;
      do @(negedge mclk); while (!rvalid);
      @(posedge mclk);
      rready <= 1'b0;
    end
  endtask
  task key;
    wr(`ADDR_GUARD, `KEY_VALUE);
  endtask
  task kick;
    begin
      @(posedge mclk);
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
    end
  endtask
  // Cycles until the next reset request, judged against a window
  task measure(input integer lo, input integer hi);
    begin
      n = 0;
      while (!rst_req && n < 200) begin
        @(negedge mclk);
        n = n + 1;
      end
      check(n >= lo && n <= hi, 34'h1);
      // Hand back on a rising edge so the next drive is edge-aligned
      @(posedge mclk);
    end
  endtask
  // Scoreboard side: oldest note against each read result
  always @(posedge mclk)
    if (rvalid && rready)
      check({rresp, rdata}, expq.pop_front());
  // Write responses against the notes of the write task
  always @(posedge mclk)
    if (bvalid && bready)
      check(bresp, bq.pop_front());
  always @(negedge mclk)
    if (rst_req)
      pulses = pulses + 1;
  // Hang guard, well above the several hundred cycles the run needs
  always @(posedge mclk) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      errors = errors + 1;
      end_of_test;
    end
  end
  initial begin
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    rd(`ADDR_STATE, 34'h0);
    rd(`ADDR_CTRL, 34'h0);
    rd(12'h010, {2'b10, 32'h0});
    wr(12'h020, 8'h00);
    seed = lfsr(seed);
    wr(`ADDR_CTRL, seed);
    rd(`ADDR_CTRL, 34'h0);
    key;
    run <= 1'b1;
    repeat (12) @(posedge mclk);
    run <= 1'b0;
    wr(`ADDR_CTRL, 8'h01);
    rd(`ADDR_CTRL, 34'h0);
    key;
    rd(`ADDR_GUARD, 34'h4);
    wr(`ADDR_CTRL, 8'h01);
    rd(`ADDR_STATE, 34'h1);
    repeat (12) @(posedge mclk);
    rd(`ADDR_STATE, 34'h0);
    rd(`ADDR_CTRL, 34'h1);
    kick;
    repeat (10) @(posedge mclk);
    p0 = pulses;
    repeat (8) begin
      kick;
      repeat (14) @(posedge mclk);
    end
    check(pulses - p0, 34'h0);
    kick;
    measure(32, 48);
    key;
    wr(`ADDR_CTRL, 8'h11);
    repeat (12) @(posedge mclk);
    kick;
    repeat (14) @(posedge mclk);
    kick;
    measure(1, 24);
    debug_halt <= 1'b1;
    repeat (8) @(posedge mclk);
    debug_halt <= 1'b0;
    repeat (4) @(posedge mclk);
    p0 = pulses;
    kick;
    repeat (46) @(posedge mclk);
    kick;
    check(pulses - p0, 34'h0);
    measure(64, 84);
    key;
    wr(`ADDR_STATE, 8'h80);
    rd(`ADDR_STATE, 34'h80);
    key;
    wr(`ADDR_CTRL, 8'h00);
    rd(`ADDR_CTRL, 34'h11);
    key;
    wr(`ADDR_STATE, 8'h00);
    rd(`ADDR_STATE, 34'h80);
    debug_mode <= 1'b1;
    repeat (4) @(posedge mclk);
    key;
    wr(`ADDR_STATE, 8'h00);
    rd(`ADDR_STATE, 34'h0);
    fuse <= 8'h03;
    boot_load <= 1'b1;
    @(posedge mclk);
    boot_load <= 1'b0;
    repeat (12) @(posedge mclk);
    rd(`ADDR_STATE, 34'h80);
    rd(`ADDR_CTRL, 34'h3);
    wr(`ADDR_CMD, 8'h01);
    measure(128, 140);
    end_of_test;
  end
endmodule
